/* File: hdl/erap_pkg.sv */
// constants shared by both ends of the two-wire eeprom read link
// assumes a single 125 MHz clock at each end
package erap_pkg;
    localparam int CLK_MHZ = 125;
    localparam int WRITE_TIME_US = 4000; // internal write cycle, plain default
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int BUSY_W = 20;
    localparam int ADDR_W = 17;
    localparam int LOW_W = 16;
    localparam int BYTE_W = 8;
    localparam int PAGE_W = 7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // control byte layout
    localparam logic [3:0] TYPE_CODE = 4'ha;
    localparam int TYPE_LSB = 4;
    localparam int HALF_BIT = 3;
    localparam int CS_MSB = 2;
    localparam int CS_LSB = 1;
    localparam int RW_BIT = 0;
    // receive byte kinds on the device side
    localparam logic [1:0] K_CTRL = 2'h0;
    localparam logic [1:0] K_AHI = 2'h1;
    localparam logic [1:0] K_ALO = 2'h2;
    localparam logic [1:0] K_DATA = 2'h3;
    // master: last divider count in a quarter of a link bit, four clock cycles per quarter
    localparam logic [1:0] Q_LAST = 2'h3;
    // master operations
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CUR = 2'h1;
    localparam logic [1:0] OP_RAND = 2'h2;
    localparam logic [1:0] OP_POLL = 2'h3;
    // master byte steps
    localparam logic [2:0] P_CW = 3'h0;
    localparam logic [2:0] P_AHI = 3'h1;
    localparam logic [2:0] P_ALO = 3'h2;
    localparam logic [2:0] P_DATA = 3'h3;
    localparam logic [2:0] P_CR = 3'h4;
    localparam logic [2:0] P_RX = 3'h5;
    // master register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_LEN = 4'h2;
    localparam logic [3:0] REG_DATA = 4'h3;
    localparam logic [3:0] REG_SEL = 4'h4;
    // status bits in the command register
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_RXV = 2;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

/* File: hdl/erap_if.sv */
// two-wire link between master and eeprom
// assumes both ends pull the data line low only; a pull-up is modelled here
`timescale 1ns/1ns
`default_nettype none
interface erap_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;
    // wired-and of both drivers with a pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
    modport host (output scl, output host_sda_o, output host_sda_oe,
                  input sda);
    modport dev (input scl, input sda, output dev_sda_o,
                 output dev_sda_oe);
endinterface
`default_nettype wire

/* File: hdl/erap_dev.sv */
// serial eeprom slave: addressing, reads, write busy and ack polling
// assumes link lines arrive asynchronously and are synchronised here
// Operation
// - no ack to control byte while busy
// - busy starts at stop ending a write
// - master repeats start and control until ack
// - polled control byte matches the pending write
// - direction bit set selects a read
// - counter holds last accessed location plus one
// - ack, send byte, stop on master nack
// - random read: address write, restart, read
// - restart after address loads pointer, no write
// - after random read pointer is next location
// - master ack fetches next byte, nack ends
// - pointer wraps inside each array half
// - control byte: type, half, selects, direction
// - high address byte first, then low
`timescale 1ns/1ns
`default_nettype none
module erap_dev #(
    parameter int unsigned WRITE_CYCLES = erap_pkg::WRITE_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    erap_if.dev bus, // link to master
    input wire logic chip_select_high, // select strap, upper
    input wire logic chip_select_low, // select strap, lower
    output logic busy // internal write cycle running
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RX = 5'h02,
        S_RACK = 5'h04,
        S_TX = 5'h08,
        S_TACK = 5'h10
    } erap_dstate_e;

    localparam int AW = erap_pkg::ADDR_W;
    localparam int BW = erap_pkg::BYTE_W;
    localparam int PW = erap_pkg::PAGE_W;
    localparam int LW = erap_pkg::LOW_W;
    localparam int TL = erap_pkg::TYPE_LSB;
    localparam int CM = erap_pkg::CS_MSB;
    localparam int CL = erap_pkg::CS_LSB;

    erap_dstate_e st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] cs_a;
    logic [1:0] cs_b;
    logic [3:0] cnt;
    logic [BW-1:0] sh;
    logic [1:0] kind;
    logic drive;
    logic rd_mode;
    logic wr_pend;
    logic [BW-1:0] pend_ctrl;
    logic [AW-1:0] ptr;
    logic [AW-1:0] ptr_next;
    logic [AW-1:0] ptr_page;
    logic [BW-1:0] rd_byte;
    logic [erap_pkg::BUSY_W-1:0] bcnt;
    logic [BW-1:0] mem [0:(1<<AW)-1];
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic byte_end;
    logic busy_hit;
    logic ctrl_ok;
    logic mem_we;

    // two-flop synchronisers, third stage is edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            cs_a <= 2'h0;
            cs_b <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
            cs_a <= {chip_select_high, chip_select_low};
            cs_b <= cs_a;
        end
    end

    // link events from synchronised lines
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    assign byte_end = scl_fall && (cnt == erap_pkg::BYTE_BITS);

    // control byte decode
    assign busy_hit = busy && (sh[BW-1:TL] == pend_ctrl[BW-1:TL]) &&
        (sh[CM:CL] == pend_ctrl[CM:CL]);
    assign ctrl_ok = (sh[BW-1:TL] == erap_pkg::TYPE_CODE) &&
        (sh[CM:CL] == cs_b) && !busy_hit;

    // next read location stays in the current half
    assign ptr_next = {ptr[AW-1], ptr[LW-1:0] + 1'b1};
    assign ptr_page = {ptr[AW-1:PW], ptr[PW-1:0] + 1'b1};
    assign rd_byte = mem[ptr];
    assign mem_we = (st == S_RX) && (kind == erap_pkg::K_DATA) &&
        byte_end && !start_c && !stop_c;

    // array storage for received data bytes
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[ptr] <= sh;
        end
    end

    // byte engine: receive, acknowledge, transmit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= S_IDLE;
            cnt <= 4'h0;
            sh <= '0;
            kind <= erap_pkg::K_CTRL;
            drive <= 1'b0;
            rd_mode <= 1'b0;
            wr_pend <= 1'b0;
            pend_ctrl <= '0;
            ptr <= '0;
        end else if (start_c) begin
            // restart drops a pending write; a write cycle already running goes on
            st <= S_RX;
            cnt <= 4'h0;
            kind <= erap_pkg::K_CTRL;
            drive <= 1'b0;
            wr_pend <= 1'b0;
        end else if (stop_c) begin
            st <= S_IDLE;
            drive <= 1'b0;
            wr_pend <= 1'b0;
        end else begin
            unique case (st)
                S_IDLE: begin
                end
                S_RX: begin
                    if (scl_rise) begin
                        sh <= {sh[BW-2:0], sda_s[1]};
                        cnt <= cnt + 1'b1;
                    end else if (byte_end) begin
                        cnt <= 4'h0;
                        if (kind == erap_pkg::K_CTRL && !ctrl_ok) begin
                            st <= S_IDLE;
                        end else begin
                            st <= S_RACK;
                            drive <= 1'b1;
                        end
                        unique case (kind)
                            erap_pkg::K_CTRL: begin
                                if (ctrl_ok) begin
                                    rd_mode <= sh[erap_pkg::RW_BIT];
                                    ptr[AW-1] <= sh[erap_pkg::HALF_BIT];
                                    kind <= erap_pkg::K_AHI;
                                    if (!sh[erap_pkg::RW_BIT]) begin
                                        pend_ctrl <= sh;
                                    end
                                end
                            end
                            erap_pkg::K_AHI: begin
                                ptr[LW-1:BW] <= sh;
                                kind <= erap_pkg::K_ALO;
                            end
                            erap_pkg::K_ALO: begin
                                ptr[BW-1:0] <= sh;
                                kind <= erap_pkg::K_DATA;
                            end
                            erap_pkg::K_DATA: begin
                                ptr <= ptr_page;
                                wr_pend <= 1'b1;
                            end
                        endcase
                    end
                end
                S_RACK: begin
                    if (scl_fall && rd_mode) begin
                        sh <= rd_byte;
                        ptr <= ptr_next;
                        drive <= ~rd_byte[BW-1];
                        cnt <= 4'h1;
                        st <= S_TX;
                    end else if (scl_fall) begin
                        drive <= 1'b0;
                        st <= S_RX;
                    end
                end
                S_TX: begin
                    if (byte_end) begin
                        drive <= 1'b0;
                        st <= S_TACK;
                    end else if (scl_fall) begin
                        drive <= ~sh[BW-2];
                        sh <= {sh[BW-2:0], 1'b0};
                        cnt <= cnt + 1'b1;
                    end
                end
                S_TACK: begin
                    if (scl_rise) begin
                        // master ack fetches the next byte
                        st <= sda_s[1] ? S_IDLE : S_RACK;
                    end
                end
            endcase
        end
    end

    // self-timed write cycle counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            bcnt <= '0;
        end else if (stop_c && wr_pend) begin
            busy <= 1'b1;
            bcnt <= erap_pkg::BUSY_W'(WRITE_CYCLES - 1);
        end else if (busy) begin
            if (bcnt == '0) begin
                busy <= 1'b0;
            end else begin
                bcnt <= bcnt - 1'b1;
            end
        end
    end

    // open-drain data drive
    assign bus.dev_sda_oe = drive;
    assign bus.dev_sda_o = 1'b0;
endmodule
`default_nettype wire

/* File: hdl/erap_host.sv */
// two-wire master: writes, current and random reads, ack polling
// assumes a register port on the same clock; link clock made by divider
`timescale 1ns/1ns
`default_nettype none
module erap_host (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    erap_if.host bus, // link to eeprom
    input wire logic [3:0] reg_addr, // register offset
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata // read data, cycle after strobe
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BYTE = 4'h4,
        H_STOP = 4'h8
    } erap_hstate_e;

    localparam int AW = erap_pkg::ADDR_W;
    localparam int BW = erap_pkg::BYTE_W;

    erap_hstate_e st;
    logic [1:0] op;
    logic [AW-1:0] tgt;
    logic [BW-1:0] len;
    logic [BW-1:0] wdata;
    logic [1:0] sel;
    logic nack;
    logic [1:0] sda_s;
    logic [1:0] qcnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [BW-1:0] sh;
    logic [2:0] step;
    logic [BW-1:0] remain;
    logic got_ack;
    logic scl_q;
    logic oe_q;
    logic [BW-1:0] fifo [0:1];
    logic wp;
    logic rp;
    logic [1:0] fcnt;
    logic tx;
    logic last;
    logic stall;
    logic tick;
    logic push;
    logic pop;
    logic at_ack;
    logic [2:0] nstep;
    logic [BW-1:0] nbyte;

    // two-flop synchroniser on the data line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_s <= 2'h3;
        end else begin
            sda_s <= {sda_s[0], bus.sda};
        end
    end

    // byte framing helpers
    assign tx = (step != erap_pkg::P_RX);
    assign last = (remain <= 8'h1);
    assign at_ack = (st == H_BYTE) && (bitn == erap_pkg::BYTE_BITS);
    assign stall = at_ack && (ph == 2'h0) && !tx &&
        (fcnt == erap_pkg::FIFO_DEPTH);
    assign tick = (st != H_IDLE) && (qcnt == erap_pkg::Q_LAST) && !stall;
    assign push = tick && at_ack && (ph == 2'h0) && !tx;
    assign pop = reg_rd && (reg_addr == erap_pkg::REG_DATA) && (fcnt != 2'h0);

    // byte to send for a step
    always_comb begin
        nstep = step;
        unique case (step)
            erap_pkg::P_CW: nstep = erap_pkg::P_AHI;
            erap_pkg::P_AHI: nstep = erap_pkg::P_ALO;
            erap_pkg::P_ALO: nstep = (op == erap_pkg::OP_WRITE) ?
                erap_pkg::P_DATA : erap_pkg::P_CR;
            erap_pkg::P_CR: nstep = erap_pkg::P_RX;
            default: nstep = step;
        endcase
    end

    always_comb begin
        unique case (nstep)
            erap_pkg::P_CW: nbyte = {erap_pkg::TYPE_CODE, tgt[AW-1], sel, 1'b0};
            erap_pkg::P_AHI: nbyte = tgt[erap_pkg::LOW_W-1:BW];
            erap_pkg::P_ALO: nbyte = tgt[BW-1:0];
            erap_pkg::P_DATA: nbyte = wdata;
            erap_pkg::P_CR: nbyte = {erap_pkg::TYPE_CODE, tgt[AW-1], sel, 1'b1};
            default: nbyte = 8'hff;
        endcase
    end

    // quarter-bit divider for the link clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qcnt <= 2'h0;
        end else if (st == H_IDLE || stall) begin
            qcnt <= 2'h0;
        end else begin
            qcnt <= qcnt + 1'b1;
        end
    end

    // link sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= H_IDLE;
            ph <= 2'h0;
            bitn <= 4'h0;
            sh <= 8'hff;
            step <= erap_pkg::P_CW;
            remain <= '0;
            got_ack <= 1'b0;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            nack <= 1'b0;
        end else if (st == H_IDLE) begin
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            ph <= 2'h0;
            if (reg_wr && reg_addr == erap_pkg::REG_CMD) begin
                st <= H_START;
                nack <= 1'b0;
                remain <= len;
                step <= (reg_wdata[1:0] == erap_pkg::OP_CUR) ?
                    erap_pkg::P_CR : erap_pkg::P_CW;
            end
        end else if (tick) begin
            ph <= ph + 1'b1;
            unique case (st)
                H_START: begin
                    // data falls while clock high
                    scl_q <= (ph == 2'h1) || (ph == 2'h2);
                    oe_q <= (ph == 2'h2) || (ph == 2'h3);
                    if (ph == 2'h3) begin
                        st <= H_BYTE;
                        bitn <= 4'h0;
                        sh <= (step == erap_pkg::P_CW) ?
                            {erap_pkg::TYPE_CODE, tgt[AW-1], sel, 1'b0} :
                            {erap_pkg::TYPE_CODE, tgt[AW-1], sel, 1'b1};
                    end
                end
                H_BYTE: begin
                    unique case (ph)
                        2'h0: oe_q <= at_ack ? (!tx && !last) : (tx && !sh[BW-1]);
                        2'h1: scl_q <= 1'b1;
                        2'h2: begin
                            if (at_ack) begin
                                got_ack <= !sda_s[1];
                            end else begin
                                sh <= {sh[BW-2:0], sda_s[1]};
                            end
                        end
                        2'h3: begin
                            scl_q <= 1'b0;
                            bitn <= bitn + 1'b1;
                            if (at_ack) begin
                                bitn <= 4'h0;
                                sh <= nbyte;
                                if (tx && !got_ack && op == erap_pkg::OP_POLL) begin
                                    st <= H_START;
                                end else if (tx && !got_ack) begin
                                    st <= H_STOP;
                                    nack <= 1'b1;
                                end else if (step == erap_pkg::P_CW &&
                                             op == erap_pkg::OP_POLL) begin
                                    st <= H_STOP;
                                end else if (step == erap_pkg::P_DATA ||
                                             (!tx && last)) begin
                                    st <= H_STOP;
                                end else if (nstep == erap_pkg::P_CR) begin
                                    st <= H_START;
                                    step <= nstep;
                                end else begin
                                    step <= nstep;
                                    if (!tx) begin
                                        remain <= remain - 1'b1;
                                    end
                                end
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    // data rises while clock high
                    scl_q <= (ph != 2'h0);
                    oe_q <= (ph == 2'h0) || (ph == 2'h1);
                    if (ph == 2'h3) begin
                        st <= H_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op <= erap_pkg::OP_WRITE;
            tgt <= '0;
            len <= 8'h1;
            wdata <= '0;
            sel <= 2'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                erap_pkg::REG_CMD: if (st == H_IDLE) op <= reg_wdata[1:0];
                erap_pkg::REG_ADDR: tgt <= reg_wdata[AW-1:0];
                erap_pkg::REG_LEN: len <= reg_wdata[BW-1:0];
                erap_pkg::REG_DATA: wdata <= reg_wdata[BW-1:0];
                erap_pkg::REG_SEL: sel <= reg_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // two-entry receive buffer; full stalls the link clock low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= 1'b0;
            rp <= 1'b0;
            fcnt <= 2'h0;
        end else begin
            if (push) begin
                fifo[wp] <= sh;
                wp <= ~wp;
            end
            if (pop) begin
                rp <= ~rp;
            end
            fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                erap_pkg::REG_CMD: reg_rdata <= {29'h0, fcnt != 2'h0, nack,
                                                 st != H_IDLE};
                erap_pkg::REG_ADDR: reg_rdata <= {15'h0, tgt};
                erap_pkg::REG_LEN: reg_rdata <= {24'h0, len};
                erap_pkg::REG_DATA: reg_rdata <= (fcnt != 2'h0) ?
                    {24'h0, fifo[rp]} : 32'h0;
                erap_pkg::REG_SEL: reg_rdata <= {30'h0, sel};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    assign bus.scl = scl_q;
    assign bus.host_sda_oe = oe_q;
    assign bus.host_sda_o = 1'b0;
endmodule
`default_nettype wire

/* File: testbench/erap_chk.sv */
// link checker: device busy timing, data edges and start ownership
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/1ns
`default_nettype none
module erap_chk #(
    parameter int unsigned WRITE_CYCLES = 200
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic scl, // link clock
    input wire logic host_sda_o, // host data
    input wire logic host_sda_oe, // host pulls low
    input wire logic dev_sda_o, // device data
    input wire logic dev_sda_oe, // device pulls low
    input wire logic sda, // wired data line
    input wire logic busy // device write cycle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    int unsigned busy_cnt;
    int unsigned since_stop;
    // busy length and distance from the last stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 0;
            since_stop <= 100;
        end else begin
            busy_cnt <= busy ? busy_cnt + 1 : 0;
            if (scl && $rose(sda)) begin
                since_stop <= 0;
            end else if (since_stop < 100) begin
                since_stop <= since_stop + 1;
            end
        end
    end
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_ack_hold;
        dev_sda_oe [*4];
    endsequence
    property p_busy_stop;
        $rose(busy) |-> since_stop < 8;
    endproperty
    a_busy_stop: assert property (p_busy_stop)
        else $error("busy began away from a stop");
    property p_busy_len;
        $fell(busy) |-> busy_cnt >= WRITE_CYCLES - 1
            && busy_cnt <= WRITE_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_busy_max;
        busy_cnt <= WRITE_CYCLES + 1;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy never cleared");
    property p_no_ack_busy;
        busy |-> !dev_sda_oe;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy)
        else $error("device drove data while busy");
    property p_dev_edge;
        $changed(dev_sda_oe) |-> !scl;
    endproperty
    a_dev_edge: assert property (p_dev_edge)
        else $error("device changed data with clock high");
    property p_dev_hold;
        $rose(dev_sda_oe) |-> s_ack_hold;
    endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("device low bit too short");
    property p_scl_high;
        $rose(scl) |-> scl [*7];
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("link clock high too short");
    property p_start_host;
        s_start |-> host_sda_oe;
    endproperty
    a_start_host: assert property (p_start_host)
        else $error("start not made by host");
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// bench: host and eeprom joined over the link, driven via registers
// assumes package, interface, both ends and checker compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    localparam int unsigned WCYC = 600;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic busy;
    logic [31:0] d;
    logic [1:0] cs = 2'h0;
    int n_fail = 0;
    int total_checks = 0;
    erap_if link ();
    erap_host erap_host_inst (.clk(clk), .rst_n(rst_n), .bus(link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    erap_dev #(.WRITE_CYCLES(WCYC)) erap_dev_inst (.clk(clk),
        .rst_n(rst_n), .bus(link), .chip_select_high(cs[1]),
        .chip_select_low(cs[0]), .busy(busy));
    erap_chk #(.WRITE_CYCLES(WCYC)) erap_chk_inst (.clk(clk),
        .rst_n(rst_n), .scl(link.scl), .host_sda_o(link.host_sda_o),
        .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .busy(busy));
    // free-running system clock
    always #4 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_bit(input int b, input logic v);
        int i;
        for (i = 0; i < 4000; i++) begin
            rd(erap_pkg::REG_CMD);
            if (d[b] === v) break;
        end
        if (i == 4000) begin
            n_fail++;
            $display("mismatch status bit %0d exp %b got %b", b, v, d[b]);
            stop_test();
        end
    endtask
    task automatic op(input logic [1:0] o);
        wr(erap_pkg::REG_CMD, {30'h0, o});
        wait_bit(erap_pkg::ST_BUSY, 1'b0);
    endtask
    // write one byte, probe while busy, then poll until acknowledged
    task automatic put(input logic [16:0] a, input logic [7:0] v);
        wr(erap_pkg::REG_ADDR, {15'h0, a});
        wr(erap_pkg::REG_DATA, {24'h0, v});
        op(erap_pkg::OP_WRITE);
        for (int i = 0; i < 16 && busy !== 1'b1; i++) @(posedge clk);
        `CHK("busy after stop", 1'b1, busy)
        op(erap_pkg::OP_CUR);
        `CHK("nack while busy", 1'b1, d[erap_pkg::ST_NACK])
        op(erap_pkg::OP_POLL);
        `CHK("busy after poll", 1'b0, busy)
    endtask
    task automatic get(input logic [7:0] e);
        wait_bit(erap_pkg::ST_RXV, 1'b1);
        rd(erap_pkg::REG_DATA);
        `CHK("read byte", e, d[7:0])
    endtask
    task automatic t_random();
        wr(erap_pkg::REG_ADDR, 32'h0ffff);
        op(erap_pkg::OP_RAND);
        get(8'ha5);
        op(erap_pkg::OP_CUR);
        get(8'h11);
        $display("random and current read done");
    endtask
    // three bytes across the upper wrap, buffer left to fill first
    task automatic t_seq();
        wr(erap_pkg::REG_LEN, 32'h3);
        wr(erap_pkg::REG_ADDR, 32'h1ffff);
        wr(erap_pkg::REG_CMD, {30'h0, erap_pkg::OP_RAND});
        repeat (1200) @(posedge clk);
        get(8'h3c);
        get(8'h22);
        get(8'h5a);
        wait_bit(erap_pkg::ST_BUSY, 1'b0);
        `CHK("buffer empty", 1'b0, d[erap_pkg::ST_RXV])
        wr(erap_pkg::REG_LEN, 32'h1);
        $display("sequential read done");
    endtask
    task automatic t_select();
        wr(erap_pkg::REG_SEL, 32'h2);
        rd(erap_pkg::REG_SEL);
        `CHK("select readback", 32'h2, d)
        op(erap_pkg::OP_CUR);
        `CHK("nack wrong select", 1'b1, d[erap_pkg::ST_NACK])
        @(posedge clk) cs <= 2'h2;
        op(erap_pkg::OP_CUR);
        `CHK("ack moved pins", 1'b0, d[erap_pkg::ST_NACK])
        @(posedge clk) cs <= 2'h0;
        wr(erap_pkg::REG_SEL, 32'h0);
        op(erap_pkg::OP_CUR);
        `CHK("ack right select", 1'b0, d[erap_pkg::ST_NACK])
        $display("select test done");
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        put(17'h0ffff, 8'ha5);
        put(17'h00000, 8'h11);
        put(17'h1ffff, 8'h3c);
        put(17'h10000, 8'h22);
        put(17'h10001, 8'h5a);
        $display("write and poll done");
        t_random();
        t_seq();
        t_select();
        stop_test();
    end
endmodule
`default_nettype wire
